// *** hw/wdt_consts.vh ***
// Register map, field positions, reset values and fixed counts of the watchdog.
// Assumes inclusion by bare name from the watchdog design files.
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH

// Register byte offsets on the AXI4-Lite slave.
`define WDT_ADDR_MODE 4'h0
`define WDT_ADDR_RELOAD 4'h4
`define WDT_ADDR_FEED 4'h8
`define WDT_ADDR_COUNT 4'hC
`define WDT_ADDR_CLKSEL 5'h10

// Mode register fields.
`define WDT_MODE_ENABLE 0
`define WDT_MODE_RESET_SEL 1
`define WDT_MODE_TIMEOUT 2
`define WDT_MODE_WDT_RESET 3
`define WDT_MODE_FEED_ERROR 4

// Reset values.
`define WDT_RESET_SEL_INIT 1'b1
`define WDT_RELOAD_INIT 24'h0000FF
`define WDT_COUNT_INIT 24'hFFFFFF

// Feed keys, written in this order.
`define WDT_FEED_KEY1 8'hAA
`define WDT_FEED_KEY2 8'h55

// Smallest reload value the counter accepts.
`define WDT_RELOAD_FLOOR 24'h0000FF

// Prescaler counts watchdog clock edges up to this value, so it divides by one more (four).
`define WDT_PRESCALE_LAST 2'h3

// Length of the system reset pulse in clk cycles.
`define WDT_RESET_PULSE_CYCLES 5'h10

// AXI response codes.
`define WDT_RESP_OKAY 2'h0
`define WDT_RESP_SLVERR 2'h2

`endif

// *** hw/wdt_prescale.v ***
// Watchdog clock selection, synchronisation and fixed divide-by-four prescaler.
// Assumes both watchdog clock sources are far slower than clk (at most a quarter of its rate).
`include "wdt_consts.vh"

module wdt_prescale (
  // System clock and reset
  input wire clk,
  input wire reset,
  // Watchdog clock sources and selection
  input wire free_running_oscillator_clk,
  input wire external_clk,
  input wire sel_external,
  // One-cycle pulse every fourth watchdog clock rising edge
  output reg tick
);

  reg [1:0] sync_osc;
  reg [1:0] sync_ext;
  reg watchdog_clock_prev;
  reg [1:0] div_count;
  wire watchdog_clock;
  wire rise;

  // Only the second synchroniser stage is read.
  assign watchdog_clock = sel_external ? sync_ext[1] : sync_osc[1];
  assign rise = watchdog_clock & ~watchdog_clock_prev;

  always @(posedge clk) begin
    if (reset) begin
      sync_osc <= 2'h0;
      sync_ext <= 2'h0;
      watchdog_clock_prev <= 1'b0;
      div_count <= 2'h0;
      tick <= 1'b0;
    end else begin
      sync_osc <= {sync_osc[0], free_running_oscillator_clk};
      sync_ext <= {sync_ext[0], external_clk};
      watchdog_clock_prev <= watchdog_clock;
      tick <= rise && (div_count == `WDT_PRESCALE_LAST);
      if (rise) begin
        div_count <= div_count + 2'h1;
      end
    end
  end

endmodule // wdt_prescale

// *** hw/wdt_top.v ***
// Watchdog timer with AXI4-Lite register slave, 24-bit down-counter and feed checker.
// Assumes software is the only party at the registers; clk is 200 MHz.
//
// What this block does
// - Once enabled, the watchdog fires a system reset, or an interrupt when reset_sel is clear, if it is not reloaded before the interval ends.
// - Software can set the enable, but only a hardware reset or a watchdog event clears it.
// - While enabled, a wrong or unfinished feed sequence fires the watchdog action itself.
// - A readable flag tells that the latest reset came from the watchdog.
// - The watchdog clock passes a fixed divide-by-four prescaler before the 24-bit counter.
// - The 24-bit counter decrements by one per prescaled tick and expires when it runs out.
// - A reload value below 0xFF is replaced by 0xFF when loaded into the counter.
// - The timeout spans 256 to 2^24 times four watchdog clock periods in steps of four periods.
// - The watchdog clock is the 2 MHz oscillator-derived clock or the external clock, as selected.
`include "wdt_consts.vh"

module wdt_top (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Watchdog clock sources
  input wire free_running_oscillator_clk,
  input wire external_clk,
  // Debug halt from the core, same clock domain
  input wire debug_halt,
  // AXI4-Lite write address
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Watchdog actions
  output reg system_reset_out,
  output reg watchdog_irq
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ARMED = 2'b10;

  reg aw_held;
  reg w_held;
  reg [4:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg enable;
  reg reset_sel;
  reg timeout_flag;
  reg wdt_reset_flag;
  reg feed_error_flag;
  reg [23:0] reload;
  reg [23:0] count;
  reg clk_sel_external;
  reg [1:0] feed_state;
  reg [1:0] next_feed_state;
  reg [4:0] pulse_count;
  reg [31:0] next_rdata;
  reg next_rerr;
  reg feed_ok;
  reg feed_bad;
  reg write_err;
  reg [23:0] next_reload;
  integer i;

  wire tick;
  wire do_write;
  wire do_read;
  wire expire;
  wire wdt_event;
  wire mode_write;
  wire [7:0] w_byte0;

  // Loaded value with the floor applied.
  function [23:0] clamp_reload;
    input [23:0] value;
    begin
      clamp_reload = (value < `WDT_RELOAD_FLOOR) ? `WDT_RELOAD_FLOOR : value;
    end
  endfunction

  wdt_prescale u_prescale (
    .clk(clk),
    .reset(reset),
    .free_running_oscillator_clk(free_running_oscillator_clk),
    .external_clk(external_clk),
    .sel_external(clk_sel_external),
    .tick(tick)
  );

  // Address and data are taken independently and held until the response is sent.
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready = ~w_held;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_read = s_axi_arvalid & ~s_axi_rvalid;
  assign w_byte0 = w_data[7:0];
  assign mode_write = do_write && (aw_addr == {1'b0, `WDT_ADDR_MODE}) && w_strb[0];

  // Count runs from the loaded value down to zero, so N+1 ticks of four watchdog clocks elapse.
  assign expire = enable && tick && !debug_halt && (count == 24'h0);
  assign wdt_event = expire || (enable && feed_bad);

  // Feed checker: any access that comes between the two keys breaks the sequence.
  always @* begin
    next_feed_state = feed_state;
    feed_ok = 1'b0;
    feed_bad = 1'b0;
    case (feed_state)
      ST_IDLE: begin
        if (do_write && aw_addr == {1'b0, `WDT_ADDR_FEED}) begin
          if (w_byte0 == `WDT_FEED_KEY1) begin
            next_feed_state = ST_ARMED;
          end else begin
            feed_bad = 1'b1;
          end
        end
      end
      ST_ARMED: begin
        if (do_write && aw_addr == {1'b0, `WDT_ADDR_FEED} && w_byte0 == `WDT_FEED_KEY2) begin
          feed_ok = 1'b1;
          next_feed_state = ST_IDLE;
        end else if (do_write || do_read) begin
          feed_bad = 1'b1;
          next_feed_state = ST_IDLE;
        end
      end
      default: begin
        next_feed_state = ST_IDLE;
      end
    endcase
  end

  // Reload register with byte lanes, and the decode of unmapped write addresses.
  always @* begin
    next_reload = reload;
    for (i = 0; i < 3; i = i + 1) begin
      if (w_strb[i]) begin
        next_reload[i*8 +: 8] = w_data[i*8 +: 8];
      end
    end
    case (aw_addr)
      {1'b0, `WDT_ADDR_MODE}, {1'b0, `WDT_ADDR_RELOAD}, {1'b0, `WDT_ADDR_FEED},
      {1'b0, `WDT_ADDR_COUNT}, `WDT_ADDR_CLKSEL: write_err = 1'b0;
      default: write_err = 1'b1;
    endcase
  end

  // Read mux; reserved bits read as zero.
  always @* begin
    next_rdata = 32'h0;
    next_rerr = 1'b0;
    case (s_axi_araddr)
      {1'b0, `WDT_ADDR_MODE}: begin
        next_rdata[`WDT_MODE_ENABLE] = enable;
        next_rdata[`WDT_MODE_RESET_SEL] = reset_sel;
        next_rdata[`WDT_MODE_TIMEOUT] = timeout_flag;
        next_rdata[`WDT_MODE_WDT_RESET] = wdt_reset_flag;
        next_rdata[`WDT_MODE_FEED_ERROR] = feed_error_flag;
      end
      {1'b0, `WDT_ADDR_RELOAD}: next_rdata = {8'h0, reload};
      {1'b0, `WDT_ADDR_FEED}: next_rdata = 32'h0;
      {1'b0, `WDT_ADDR_COUNT}: next_rdata = {8'h0, count};
      `WDT_ADDR_CLKSEL: next_rdata = {31'h0, clk_sel_external};
      default: next_rerr = 1'b1;
    endcase
  end

  // Bus channels.
  always @(posedge clk) begin
    if (reset) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 5'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WDT_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `WDT_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[4:2], 2'h0};
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= write_err ? `WDT_RESP_SLVERR : `WDT_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rerr ? `WDT_RESP_SLVERR : `WDT_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Watchdog core.
  always @(posedge clk) begin
    if (reset) begin
      enable <= 1'b0;
      reset_sel <= `WDT_RESET_SEL_INIT;
      timeout_flag <= 1'b0;
      wdt_reset_flag <= 1'b0;
      feed_error_flag <= 1'b0;
      reload <= `WDT_RELOAD_INIT;
      count <= `WDT_COUNT_INIT;
      clk_sel_external <= 1'b0;
      feed_state <= ST_IDLE;
      pulse_count <= 5'h0;
      system_reset_out <= 1'b0;
      watchdog_irq <= 1'b0;
    end else begin
      feed_state <= next_feed_state;
      watchdog_irq <= wdt_event && !reset_sel;
      if (wdt_event) begin
        enable <= 1'b0;
        count <= `WDT_COUNT_INIT;
      end else begin
        if (mode_write && w_data[`WDT_MODE_ENABLE] && !enable) begin
          enable <= 1'b1;
          count <= clamp_reload(reload);
        end else if (feed_ok) begin
          count <= clamp_reload(reload);
        end else if (enable && tick && !debug_halt) begin
          count <= count - 24'h1;
        end
      end
      // Action select is locked while running, so a running watchdog cannot be softened.
      if (mode_write && !enable) begin
        reset_sel <= w_data[`WDT_MODE_RESET_SEL];
      end
      // Hardware events set the flags; a same-cycle write-one-to-clear loses.
      if (expire) begin
        timeout_flag <= 1'b1;
      end else if (mode_write && w_data[`WDT_MODE_TIMEOUT]) begin
        timeout_flag <= 1'b0;
      end
      if (enable && feed_bad) begin
        feed_error_flag <= 1'b1;
      end else if (mode_write && w_data[`WDT_MODE_FEED_ERROR]) begin
        feed_error_flag <= 1'b0;
      end
      if (wdt_event && reset_sel) begin
        wdt_reset_flag <= 1'b1;
      end else if (mode_write && w_data[`WDT_MODE_WDT_RESET]) begin
        wdt_reset_flag <= 1'b0;
      end
      if (do_write && aw_addr == {1'b0, `WDT_ADDR_RELOAD}) begin
        reload <= next_reload;
      end
      if (do_write && aw_addr == `WDT_ADDR_CLKSEL && w_strb[0]) begin
        clk_sel_external <= w_data[0];
      end
      if (wdt_event && reset_sel) begin
        pulse_count <= `WDT_RESET_PULSE_CYCLES;
        system_reset_out <= 1'b1;
      end else if (pulse_count != 5'h0) begin
        pulse_count <= pulse_count - 5'h1;
        system_reset_out <= (pulse_count != 5'h1);
      end
    end
  end

endmodule // wdt_top

// *** tb/wdt_top_sva.sv ***
// Concurrent checks on the watchdog register slave and its reset and interrupt outputs.
// Assumes it is bound to wdt_top and sees only that module's ports.
module wdt_checker (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Watchdog actions
  input wire system_reset_out,
  input wire watchdog_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] pulse_len;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // The pulse is longer than a repetition may span, so its length is counted here.
  always @(posedge clk) begin
    if (reset || !system_reset_out)
      pulse_len <= 5'h00;
    else
      pulse_len <= pulse_len + 5'h01;
  end
  chk_pulse_length: assert property ($fell(system_reset_out) |-> pulse_len == 5'h10)
    else $error("reset pulse length wrong");
  chk_irq_single: assert property (watchdog_irq |=> !watchdog_irq)
    else $error("interrupt pulse too long");
  chk_one_action: assert property (!(watchdog_irq && system_reset_out))
    else $error("reset and interrupt together");
  // Address and data are registered before the write is done, so the response is seen two edges on.
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 5'h13 |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  cover property ($rose(system_reset_out));
  cover property (watchdog_irq);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // wdt_checker

bind wdt_top wdt_checker u_chk (.clk(clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .system_reset_out(system_reset_out), .watchdog_irq(watchdog_irq));

// *** tb/test_watchdog_timer_24bit.sv ***
// Self-checking bench for the watchdog: register table, timeout, feed and error handling.
// Assumes the external watchdog clock is selected for the timed cases, at an eighth of clk.
`define CHECK_EQ(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); n_errors++; end end

module test_watchdog_timer_24bit;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {bit wr; logic [4:0] a; logic [31:0] d; logic [31:0] exp; logic [1:0] resp;} wdt_row_t;
  logic clk = 1'b0, reset = 1'b1, free_running_oscillator_clk = 1'b0, external_clk = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, system_reset_out, watchdog_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int i, cyc, n_irq = 0, n_rst = 0, n_errors = 0, total_checks = 0;
  time t0;
  wdt_row_t rows [10] = '{'{1'b0, 5'h00, 32'h0, 32'h2, 2'h0}, '{1'b0, 5'h04, 32'h0, 32'hFF, 2'h0},
    '{1'b0, 5'h0C, 32'h0, 32'hFFFFFF, 2'h0}, '{1'b0, 5'h08, 32'h0, 32'h0, 2'h0},
    '{1'b0, 5'h14, 32'h0, 32'h0, 2'h2}, '{1'b1, 5'h14, 32'h1, 32'h0, 2'h2},
    '{1'b1, 5'h00, 32'h0, 32'h0, 2'h0}, '{1'b0, 5'h00, 32'h0, 32'h0, 2'h0},
    '{1'b1, 5'h10, 32'h1, 32'h0, 2'h0}, '{1'b0, 5'h10, 32'h0, 32'h1, 2'h0}};

  wdt_top DUT (.clk(clk), .reset(reset), .free_running_oscillator_clk(free_running_oscillator_clk),
    .external_clk(external_clk), .debug_halt(1'b0), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .system_reset_out(system_reset_out), .watchdog_irq(watchdog_irq));

  always #2.5 clk = ~clk;
  always #250 free_running_oscillator_clk = ~free_running_oscillator_clk;
  // Odd start offset keeps the external clock out of phase with clk.
  initial begin
    #3;
    forever #20 external_clk = ~external_clk;
  end
  always @(posedge clk) begin
    if (watchdog_irq) n_irq <= n_irq + 1;
    if ($rose(system_reset_out)) n_rst <= n_rst + 1;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    n_errors++;
    report_and_stop;
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    n_errors++;
    report_and_stop;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[j]) begin
      if (rows[j].wr) begin
        wr(rows[j].a, rows[j].d, rs);
      end else begin
        rd(rows[j].a, rd_data, rs);
        `CHECK_EQ(rd_data, rows[j].exp);
      end
      `CHECK_EQ(rs, rows[j].resp);
    end
    $display("test register table done");
    wr(5'h04, 32'h10, rs);
    wr(5'h00, 32'h3, rs);
    t0 = $time;
    rd(5'h0C, rd_data, rs);
    `CHECK_EQ(rd_data >= 32'hFE && rd_data <= 32'hFF, 1'b1);
    wr(5'h00, 32'h0, rs);
    rd(5'h00, rd_data, rs);
    `CHECK_EQ(rd_data[0], 1'b1);
    for (i = 0; i < 9000 && !system_reset_out; i++) @(posedge clk);
    `CHECK_EQ(system_reset_out, 1'b1);
    if (!system_reset_out) report_and_stop;
    cyc = ($time - t0) / 5;
    // 256 ticks of 32 clk cycles each; the free-running prescaler phase takes off up to one tick.
    `CHECK_EQ(cyc > 8150 && cyc < 8210, 1'b1);
    repeat (20) @(posedge clk);
    rd(5'h00, rd_data, rs);
    `CHECK_EQ(rd_data, 32'hE);
    $display("test timeout done");
    wr(5'h00, 32'h1C, rs);
    wr(5'h04, 32'h300, rs);
    wr(5'h00, 32'h1, rs);
    repeat (400) @(posedge clk);
    wr(5'h08, 32'hAA, rs);
    wr(5'h08, 32'h55, rs);
    rd(5'h0C, rd_data, rs);
    `CHECK_EQ(rd_data >= 32'h2FE && rd_data <= 32'h300, 1'b1);
    wr(5'h08, 32'hAA, rs);
    rd(5'h00, rd_data, rs);
    for (i = 0; i < 20 && n_irq == 0; i++) @(posedge clk);
    `CHECK_EQ(n_irq, 1);
    if (n_irq == 0) report_and_stop;
    `CHECK_EQ(n_rst, 1);
    rd(5'h00, rd_data, rs);
    `CHECK_EQ(rd_data, 32'h10);
    $display("test feed done");
    report_and_stop;
  end
endmodule // test_watchdog_timer_24bit
